// >>> design/ddrcad_decoder.sv
// Command/address header decoder for an eight-bit DDR memory bus.
// Assumes the bus clock is far slower than sys_clk (oversampled), and
// that the host holds each byte stable around its clock edge.
`timescale 1ns/1ps
module ddrcad_decoder (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        busClk,
  input  wire logic        clock_complement,
  input  wire logic        chipSelN,
  input  wire logic [7:0]  busData,
  input  wire logic        refreshPending,
  input  wire logic        nextHalfPage,
  output logic             strobe_mask_line_out,
  output logic             strobe_mask_line_oe_n,
  output logic             headerValid,
  output logic             isRead,
  output logic             target_space_flag,
  output logic             linearBurst,
  output logic [28:0]      rowAddr,
  output logic [2:0]       colAddr,
  output logic             accessStart,
  output logic [28:0]      accessHalfPage
);
  // =====================================================
  // Input synchronisation
  logic [10:0] syncBus;
  logic        clkS;
  logic        clkNS;
  logic        csNS;
  logic [7:0]  dataS;

  // Reset levels match the idle pins, so no false select
  // edge appears while the synchroniser fills after reset.
  ddrcad_sync #(
    .W       (11),
    .RST_VAL (ddrcad_pkg::SYNC_IDLE)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .asyncIn ({busClk, clock_complement, chipSelN, busData}),
    .syncOut (syncBus)
  );
  assign clkS  = syncBus[10];
  assign clkNS = syncBus[9];
  assign csNS  = syncBus[8];
  assign dataS = syncBus[7:0];

  // =====================================================
  // Edge detection
  logic clkPrev_reg;
  logic csPrev_reg;
  logic clkEdge;
  logic csFall;
  logic csRise;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkPrev_reg <= 1'b0;
      csPrev_reg  <= 1'b1;
    end else begin
      clkPrev_reg <= clkS;
      csPrev_reg  <= csNS;
    end
  end
  // Clock and data share one sync delay, so the byte
  // is already settled in the cycle its edge is seen.
  // either clock edge
  assign clkEdge = clkS ^ clkPrev_reg;
  assign csFall  = csPrev_reg & ~csNS;
  assign csRise  = ~csPrev_reg & csNS;

  // =====================================================
  // Header state machine
  ddrcad_pkg::ddrcad_state_t state_reg;
  logic [2:0]  byteCnt_reg;
  logic [47:0] hdr_reg;
  logic        lastByte;
  logic        rowByte;

  assign lastByte = clkEdge && byteCnt_reg == ddrcad_pkg::CNT_LAST;
  assign rowByte  = clkEdge && byteCnt_reg == (ddrcad_pkg::CNT_ROW - 3'h1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ddrcad_pkg::DDRCAD_IDLE;
    end else begin
      unique case (state_reg)
        ddrcad_pkg::DDRCAD_IDLE: begin
          // start only with clock idle low
          // A fall with the clock mid-cycle waits for the next fall
          if (csFall && !clkS && clkNS) begin
            state_reg <= ddrcad_pkg::DDRCAD_HEADER;
          end
        end
        ddrcad_pkg::DDRCAD_HEADER: begin
          if (csNS) begin
            state_reg <= ddrcad_pkg::DDRCAD_IDLE;
          end else if (lastByte) begin
            state_reg <= ddrcad_pkg::DDRCAD_DONE;
          end
        end
        ddrcad_pkg::DDRCAD_DONE: begin
          // fresh header needed after select rises
          if (csNS) begin
            state_reg <= ddrcad_pkg::DDRCAD_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      byteCnt_reg <= ddrcad_pkg::CNT_ZERO;
    end else if (state_reg != ddrcad_pkg::DDRCAD_HEADER) begin
      byteCnt_reg <= ddrcad_pkg::CNT_ZERO;
    end else if (clkEdge && byteCnt_reg != ddrcad_pkg::CNT_LAST) begin
      byteCnt_reg <= byteCnt_reg + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_reg <= ddrcad_pkg::HDR_RESET;
    end else if (state_reg == ddrcad_pkg::DDRCAD_HEADER && clkEdge && !csNS) begin
      hdr_reg <= {hdr_reg[39:0], dataS};
    end
  end

  // =====================================================
  // Decoded fields, latched after the sixth edge
  // Select high outranks a finishing header: a cut frame never shows valid
  logic [47:0] full;
  assign full = {hdr_reg[39:0], dataS};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      headerValid       <= 1'b0;
      isRead            <= 1'b0;
      target_space_flag <= 1'b0;
      linearBurst       <= 1'b0;
      rowAddr           <= '0;
      colAddr           <= '0;
    end else if (csNS) begin
      headerValid <= 1'b0;
    end else if (state_reg == ddrcad_pkg::DDRCAD_HEADER && lastByte) begin
      headerValid       <= 1'b1;
      isRead            <= full[ddrcad_pkg::BIT_DIR];
      target_space_flag <= full[ddrcad_pkg::BIT_SPACE];
      linearBurst       <= full[ddrcad_pkg::BIT_BURST];
      // row and upper column, split left to the core
      rowAddr           <= full[ddrcad_pkg::ROW_HI:ddrcad_pkg::ROW_LO];
      // bits 15..3 dropped. word within half-page
      colAddr           <= full[ddrcad_pkg::COL_HI:0];
    end
  end

  // =====================================================
  // Early array access and half-page interleave
  // half-page index is the row/upper column field
  // Core must pulse nextHalfPage once; a held level refetches every cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      accessStart    <= 1'b0;
      accessHalfPage <= '0;
    end else begin
      accessStart <= 1'b0;
      if (state_reg == ddrcad_pkg::DDRCAD_HEADER && rowByte && !csNS) begin
        // start before the last header word
        accessStart    <= 1'b1;
        accessHalfPage <= {hdr_reg[20:0], dataS};
      end else if (state_reg == ddrcad_pkg::DDRCAD_DONE && linearBurst && isRead
                   && nextHalfPage && !csNS) begin
        accessStart    <= 1'b1;
        accessHalfPage <= accessHalfPage + ddrcad_pkg::ROW_ONE;
      end
    end
  end

  // =====================================================
  // Strobe drive during header
  // refresh latency request
  // Line is released outside the header so the host may drive it later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_mask_line_out  <= 1'b0;
      strobe_mask_line_oe_n <= 1'b1;
    end else begin
      strobe_mask_line_oe_n <= !(state_reg == ddrcad_pkg::DDRCAD_HEADER && !csNS);
      strobe_mask_line_out  <= refreshPending;
    end
  end
endmodule

// >>> design/ddrcad_pkg.sv
// Constants for the DDR command/address header decoder.
// Assumes a 10 MHz system clock that oversamples the host bus clock.
package ddrcad_pkg;
  // =====================================================
  // Header layout
  localparam int HDR_BYTES      = 6;
  localparam int HDR_BITS       = 48;
  localparam int BIT_DIR        = 47;
  localparam int BIT_SPACE      = 46;
  localparam int BIT_BURST      = 45;
  localparam int ROW_HI         = 44;
  localparam int ROW_LO         = 16;
  localparam int ROW_W          = 29;
  localparam int COL_HI         = 2;
  localparam int COL_W          = 3;
  localparam int ROW_DONE_BYTES = 4;
  localparam int HALF_PAGE_WORDS = 8;
  localparam int HALF_PAGE_BYTES = 16;
  localparam int WORD_BITS      = 16;
  localparam logic [47:0] HDR_RESET = 48'h000000000000;
  localparam logic [2:0]  CNT_ZERO  = 3'h0;
  localparam logic [2:0]  CNT_ROW   = 3'h4;
  localparam logic [2:0]  CNT_LAST  = 3'h5;
  localparam logic [28:0] ROW_ONE   = 29'h00000001;
  // Synchroniser reset levels: select high, complement clock high
  localparam logic [10:0] SYNC_IDLE = 11'h300;

  typedef enum logic [1:0] {
    DDRCAD_IDLE,
    DDRCAD_HEADER,
    DDRCAD_DONE
  } ddrcad_state_t;
endpackage

// >>> design/ddrcad_sync.sv
// Two-flop synchroniser, one per input bit.
// Assumes the inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
module ddrcad_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_reg;

  // =====================================================
  // Synchroniser stages
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[gi] <= RST_VAL[gi];
          syncOut[gi]  <= RST_VAL[gi];
        end else begin
          meta_reg[gi] <= asyncIn[gi];
          syncOut[gi]  <= meta_reg[gi];
        end
      end
    end
  endgenerate
endmodule

// >>> verification/ddrcad_decoder_props.sv
// Port assertions for the header decoder.
// Assumes one sys_clk domain; bound to every decoder.
`timescale 1ns/1ps
module ddrcad_decoder_props (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        chipSelN,
  input wire logic        refreshPending,
  input wire logic        nextHalfPage,
  input wire logic        strobe_mask_line_out,
  input wire logic        strobe_mask_line_oe_n,
  input wire logic        headerValid,
  input wire logic        isRead,
  input wire logic        linearBurst,
  input wire logic        accessStart,
  input wire logic [28:0] rowAddr,
  input wire logic [2:0]  colAddr,
  input wire logic [28:0] accessHalfPage
);
  // ==========
  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_STROBE: assert property (
    !strobe_mask_line_oe_n |-> strobe_mask_line_out == $past(refreshPending))
    else $error("strobe line not tracking refresh");
  AST_OE_ON: assert property (
    $fell(chipSelN) |-> ##[1:5] !strobe_mask_line_oe_n) else $error("strobe line not driven");
  AST_OE_OFF: assert property (
    $rose(chipSelN) |-> ##[1:5] strobe_mask_line_oe_n) else $error("strobe line not released");
  AST_HV_DROP: assert property (
    $rose(chipSelN) |-> ##[1:5] !headerValid) else $error("valid kept after select high");
  AST_HV_FRESH: assert property (
    $fell(strobe_mask_line_oe_n) |-> !headerValid) else $error("stale valid at new header");
  AST_STABLE: assert property (
    headerValid && $past(headerValid) |-> $stable(rowAddr) && $stable(colAddr) && $stable(isRead))
    else $error("fields moved while valid");
  AST_PULSE: assert property (
    accessStart |=> !accessStart) else $error("access request longer than one cycle");
  AST_ROW: assert property (
    $rose(headerValid) |-> accessHalfPage == rowAddr) else $error("access row differs");
  AST_NEXT: assert property (
    nextHalfPage && headerValid && isRead && linearBurst |=>
      accessStart && accessHalfPage == $past(accessHalfPage) + 29'h00000001)
    else $error("next half-page not fetched");
endmodule
bind ddrcad_decoder ddrcad_decoder_props u_props (.*);

// >>> verification/ddrcad_host_model.sv
// Bus host model: sends header bytes on its bus clock.
// Assumes the caller runs its tasks from the sys_clk bench.
`timescale 1ns/1ps
module ddrcad_host_model (
  input  wire logic       sys_clk,
  output logic            busClk,
  output logic            clock_complement,
  output logic            chipSelN,
  output logic [7:0]      busData
);
  // ==========
  // Bus cycles, half period four sys clocks
  initial begin
    busClk = 1'b0;
    clock_complement = 1'b1;
    chipSelN = 1'b1;
    busData = 8'h00;
  end
  task automatic send(input logic [47:0] h, input int n);
    @(negedge sys_clk) chipSelN = 1'b0;
    repeat (2) @(negedge sys_clk);
    for (int k = 0; k < n; k++) begin
      busData = h[47 - 8 * k -: 8];
      repeat (2) @(negedge sys_clk);
      busClk = ~busClk;
      clock_complement = ~busClk;
      repeat (2) @(negedge sys_clk);
    end
  endtask
  task automatic release_bus();
    // select high before next header; released data not held
    chipSelN = 1'b1;
    busData = ~busData;
    repeat (4) @(negedge sys_clk);
    busClk = 1'b0;
    clock_complement = 1'b1;
  endtask
endmodule

// >>> verification/ddrcad_decoder_tb.sv
// Random header testbench for the decoder.
// Assumes the host model drives the bus side.
`timescale 1ns/1ps
module ddrcad_decoder_tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, refreshPending = 1'b0, nextHalfPage = 1'b0;
  logic busClk, clock_complement, chipSelN, strobe_mask_line_out, strobe_mask_line_oe_n;
  logic headerValid, isRead, target_space_flag, linearBurst, accessStart;
  logic [7:0] busData;
  logic [28:0] rowAddr, accessHalfPage;
  logic [2:0] colAddr;
  logic [47:0] h;
  int seed = 55, miscompares = 0, compares = 0, cyc = 0, starts = 0;
  logic [28:0] startAddr;
  logic drove, strbSeen;
  // ==========
  // Harness
  initial forever #50 sys_clk = ~sys_clk;
  ddrcad_host_model host (.sys_clk(sys_clk), .busClk(busClk),
    .clock_complement(clock_complement), .chipSelN(chipSelN), .busData(busData));
  ddrcad_decoder dut (.sys_clk(sys_clk), .rst_n(rst_n), .busClk(busClk),
    .clock_complement(clock_complement), .chipSelN(chipSelN), .busData(busData),
    .refreshPending(refreshPending), .nextHalfPage(nextHalfPage),
    .strobe_mask_line_out(strobe_mask_line_out),
    .strobe_mask_line_oe_n(strobe_mask_line_oe_n), .headerValid(headerValid),
    .isRead(isRead), .target_space_flag(target_space_flag), .linearBurst(linearBurst),
    .rowAddr(rowAddr), .colAddr(colAddr), .accessStart(accessStart),
    .accessHalfPage(accessHalfPage));
  task automatic chk(input string n, input logic [28:0] e, input logic [28:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watch array requests and strobe drive during each header
  always @(negedge sys_clk) begin
    if (accessStart) begin
      starts++;
      startAddr = accessHalfPage;
    end
    if (!strobe_mask_line_oe_n) begin
      drove = 1'b1;
      strbSeen = strobe_mask_line_out;
    end
  end
  // Timeout well above eight headers
  always @(posedge sys_clk) if (++cyc > 20000) begin
    miscompares++;
    summarize();
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      h = 48'({$random(seed), $random(seed)});
      if (i > 0) h[15:3] = 13'h0000;
      // Corner: linear read of the array
      if (i == 2) h[47:45] = 3'h5;
      if (i > 2) h[44:41] = 4'h0;
      if (i == 1) begin
        host.send(h, 3);
        host.release_bus();
        repeat (6) @(negedge sys_clk);
        chk("partial valid", 29'h0, {28'h0, headerValid});
      end
      refreshPending = i[0];
      starts = 0;
      drove = 1'b0;
      host.send(h, 6);
      repeat (6) @(negedge sys_clk);
      chk("valid", 29'h1, {28'h0, headerValid});
      chk("read", h[47], isRead);
      chk("space", h[46], target_space_flag);
      chk("linear", h[45], linearBurst);
      chk("row", h[44:16], rowAddr);
      chk("col", h[2:0], colAddr);
      chk("strobe", i[0], strobe_mask_line_out);
      chk("strobe driven", 29'h1, {28'h0, drove});
      chk("strobe in header", i[0], strbSeen);
      chk("early starts", 29'h1, 29'(starts));
      chk("early row", h[44:16], startAddr);
      nextHalfPage = 1'b1;
      @(negedge sys_clk) nextHalfPage = 1'b0;
      chk("half page", h[44:16] + ((h[47] && h[45]) ? 29'h1 : 29'h0), accessHalfPage);
      host.release_bus();
      repeat (6) @(negedge sys_clk);
      chk("valid off", 29'h0, {28'h0, headerValid});
      $display("test %0d done", i);
    end
    summarize();
  end
endmodule
